// file: bist_consts.svh
`ifndef BIST_CONSTS_SVH
`define BIST_CONSTS_SVH

// ***************************************************************
// register offsets on the register port
// ***************************************************************
`define REG_GEN_CTRL 3'h0
`define REG_CHK_CTRL 3'h1
`define REG_USER_W0 3'h2
`define REG_USER_W1 3'h3
`define REG_USER_W2 3'h4
`define REG_CHK_CHSEL 3'h5
`define REG_GEN_CHSEL 3'h6
`define REG_CHK_ERRCNT 3'h7

// ***************************************************************
// field positions and reset values
// ***************************************************************
`define CTRL_RST_BIT 0
`define CTRL_EN_BIT 1
`define CTRL_SEL_LSB 2
`define CTRL_SEL_MSB 5
`define CHK_CLR_BIT 6
`define GEN_REFSEL_BIT 6
`define GEN_ERRINJ_BIT 7
`define GEN_CTRL_RESET 8'h01
`define CHK_CTRL_RESET 8'h01
`define ZERO_RESET 8'h00
`define ERR_MAX 8'hFF

// ***************************************************************
// pattern lengths and checker timing
// ***************************************************************
`define PRBS7_LEN 7
`define PRBS7_TAP 6
`define PRBS15_LEN 15
`define PRBS15_TAP 14
`define PRBS23_LEN 23
`define PRBS23_TAP 18
`define PRBS31_LEN 31
`define PRBS31_TAP 28
`define USER16_LAST 5'h0F
`define USER20_LAST 5'h13
`define SYM_LAST 5'h09
`define LOCK_RUN 7'h40

`endif

// file: bist_pkg.sv
package bist_pkg;

   typedef enum logic [3:0] {
      SEL_PRBS7 = 4'h0,
      SEL_PRBS15 = 4'h1,
      SEL_PRBS23 = 4'h2,
      SEL_PRBS31 = 4'h3,
      SEL_JITTER = 4'h4,
      SEL_RANDOM = 4'h5,
      SEL_COUNTDOWN = 4'h6,
      SEL_USER16 = 4'h7,
      SEL_USER20 = 4'h8
   } pat_sel_t;

   typedef struct packed {
      logic [30:0] lfsr;
      logic [9:0] word;
      logic [4:0] bitCnt;
      logic [7:0] byteCnt;
      logic rd;
   } pat_state_t;

   typedef enum logic [1:0] {
      CHK_HUNT = 2'b01,
      CHK_LOCK = 2'b10
   } chk_state_t;

   typedef struct packed {
      logic [7:0] genCtrl;
      logic [7:0] chkCtrl;
      logic [23:0] userPat;
      logic [7:0] chkChSel;
      logic [7:0] genChSel;
   } bist_regs_t;

endpackage

// file: bist_fifo.sv
`timescale 1ns/1ps
module bist_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 8
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic flush,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
   localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
   logic [AW:0] count_q, count_d;
   logic push, pop;

   assign inReady = (count_q != FULL_CNT) && !flush;
   assign outValid = (count_q != '0) && !flush;
   assign outData = mem[rdPtr_q];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_comb begin
      wrPtr_d = wrPtr_q;
      rdPtr_d = rdPtr_q;
      count_d = count_q;
      if (flush) begin
         wrPtr_d = '0;
         rdPtr_d = '0;
         count_d = '0;
      end else begin
         if (push) begin
            wrPtr_d = (wrPtr_q == LAST_PTR) ? '0 : wrPtr_q + 1'b1;
         end
         if (pop) begin
            rdPtr_d = (rdPtr_q == LAST_PTR) ? '0 : rdPtr_q + 1'b1;
         end
         if (push && !pop) begin
            count_d = count_q + 1'b1;
         end else if (pop && !push) begin
            count_d = count_q - 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end else begin
         wrPtr_q <= wrPtr_d;
         rdPtr_q <= rdPtr_d;
         count_q <= count_d;
      end
   end

   // storage carries no reset; only the pointers and count decide what is valid
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wrPtr_q] <= inData;
      end
   end
endmodule

// file: bist_pattern_gen_checker.sv
`timescale 1ns/1ps
`include "bist_consts.svh"
// Contract
// - codes 0-3 select the four prbs polynomials
// - codes 4-6 select jitter, random, countdown
// - countdown encodes 255 down to 0, disparity kept
// - codes 7/8 use 16/20-bit user pattern
// - generator and checker share user pattern registers
// - pattern code from control bits 5:2 each
// - checker enable bit1 off, reset bit0 set
// - checker watches one channel from select 2:0
// - checker runs on selected recovered clock
// - errors count up, saturating at ffh
// - writing one to bit6 clears errors
// - checker aligns to incoming data by itself
// - generator drives channels 0,1; both sides concurrent
// - multiplier reference external or checked channel, full-rate
// - generator enable bit1 off, reset bit0 set
// - generator bit6 picks multiplier reference
// - bit7 written 0,1,0 corrupts one bit
module bist_pattern_gen_checker
   import bist_pkg::*;
#(
   parameter int FIFO_DEPTH = 8,
   parameter int CHANNELS = 4,
   parameter logic [63:0] JITTER_BYTES = 64'h7E7E_7E7E_FEFE_FEFE,
   parameter logic [63:0] RANDOM_BYTES = 64'hBC95_B5D7_273A_16C4
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic regWrEn,
   input wire logic [2:0] regAddr,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData_q,
   input wire logic [CHANNELS-1:0] recClk,
   input wire logic [CHANNELS-1:0] recData,
   input wire logic checkChanFullRate,
   input wire logic genBitTick,
   output logic txData0_q,
   output logic txData1_q,
   output logic pllRefRecovered_q,
   output logic chkLocked_q
);
   localparam int NSYNC = 2 * CHANNELS + 1;

   // ***************************************************************
   // shared pattern functions
   // ***************************************************************
   localparam logic [5:0] SIX_TAB [32] = '{
      6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
      6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
      6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
      6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
   localparam logic [3:0] FOUR_TAB [8] = '{
      4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

   // rd high means positive running disparity; result is {rd, abcdei, fghj}
   function automatic logic [10:0] enc8b10b(input logic [7:0] d, input logic rd);
      logic [5:0] six;
      logic [3:0] four;
      logic sixUnb;
      logic rdMid;
      logic alt;
      six = SIX_TAB[d[4:0]];
      sixUnb = ($countones(six) != 3);
      if (rd && (sixUnb || d[4:0] == 5'h07)) begin
         six = ~six;
      end
      rdMid = sixUnb ? ~rd : rd;
      alt = (d[7:5] == 3'h7) &&
            ((!rdMid && (d[4:0] == 5'h11 || d[4:0] == 5'h12 || d[4:0] == 5'h14)) ||
             (rdMid && (d[4:0] == 5'h0B || d[4:0] == 5'h0D || d[4:0] == 5'h0E)));
      four = alt ? 4'h7 : FOUR_TAB[d[7:5]];
      if (rdMid && (d[7:5] == 3'h0 || d[7:5] == 3'h3 || d[7:5] == 3'h4 || d[7:5] == 3'h7)) begin
         four = ~four;
      end
      if (d[7:5] == 3'h0 || d[7:5] == 3'h4 || d[7:5] == 3'h7) begin
         rdMid = ~rdMid;
      end
      return {rdMid, six, four};
   endfunction

   function automatic logic [7:0] srcByte(input logic [3:0] sel, input logic [7:0] cnt);
      logic [7:0] b;
      b = cnt;
      if (sel == SEL_JITTER) begin
         b = JITTER_BYTES[{cnt[2:0], 3'h0} +: 8];
      end else if (sel == SEL_RANDOM) begin
         b = RANDOM_BYTES[{cnt[2:0], 3'h0} +: 8];
      end
      return b;
   endfunction

   function automatic logic patBit(input pat_state_t st, input logic [3:0] sel,
                                   input logic [23:0] user);
      logic b;
      b = 1'b0;
      unique case (sel)
         SEL_PRBS7: b = st.lfsr[`PRBS7_LEN-1] ^ st.lfsr[`PRBS7_TAP-1];
         SEL_PRBS15: b = st.lfsr[`PRBS15_LEN-1] ^ st.lfsr[`PRBS15_TAP-1];
         SEL_PRBS23: b = st.lfsr[`PRBS23_LEN-1] ^ st.lfsr[`PRBS23_TAP-1];
         SEL_PRBS31: b = st.lfsr[`PRBS31_LEN-1] ^ st.lfsr[`PRBS31_TAP-1];
         SEL_JITTER, SEL_RANDOM, SEL_COUNTDOWN: b = st.word[4'h9 - st.bitCnt[3:0]];
         SEL_USER16: b = user[`USER16_LAST - st.bitCnt];
         SEL_USER20: b = user[`USER20_LAST - st.bitCnt];
         default: b = 1'b0;
      endcase
      return b;
   endfunction

   // useRx loads the received bit into the prbs register so the checker self-syncs
   function automatic pat_state_t patStep(input pat_state_t st, input logic [3:0] sel,
                                          input logic useRx, input logic rx,
                                          input logic [23:0] user);
      pat_state_t n;
      logic [10:0] enc;
      n = st;
      enc = '0;
      if (sel <= SEL_PRBS31) begin
         n.lfsr = {st.lfsr[29:0], useRx ? rx : patBit(st, sel, user)};
      end else if (sel == SEL_USER16) begin
         n.bitCnt = (st.bitCnt == `USER16_LAST) ? 5'h00 : st.bitCnt + 5'h01;
      end else if (sel == SEL_USER20) begin
         n.bitCnt = (st.bitCnt == `USER20_LAST) ? 5'h00 : st.bitCnt + 5'h01;
      end else if (st.bitCnt == `SYM_LAST) begin
         enc = enc8b10b(srcByte(sel, st.byteCnt), st.rd);
         n.rd = enc[10];
         n.word = enc[9:0];
         n.bitCnt = 5'h00;
         n.byteCnt = (sel == SEL_COUNTDOWN) ? st.byteCnt - 8'h01 : st.byteCnt + 8'h01;
      end else begin
         n.bitCnt = st.bitCnt + 5'h01;
      end
      return n;
   endfunction

   localparam pat_state_t PAT_INIT = '{lfsr: '1, word: '0, bitCnt: `SYM_LAST,
                                       byteCnt: 8'hFF, rd: 1'b0};

   // ***************************************************************
   // input synchronisers
   // ***************************************************************
   logic [NSYNC-1:0] sync1_q, sync2_q, syncPrev_q;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_q <= '0;
         sync2_q <= '0;
         syncPrev_q <= '0;
      end else begin
         sync1_q <= {genBitTick, recData, recClk};
         sync2_q <= sync1_q;
         syncPrev_q <= sync2_q;
      end
   end

   // ***************************************************************
   // registers
   // ***************************************************************
   bist_regs_t regs_q, regs_d;
   logic [7:0] errCnt_q, errCnt_d;
   logic [7:0] rdData_d;
   logic errClear, injectReq, chkEvent, chkError;
   logic genActive, chkActive;
   logic [3:0] genSel, chkSel;

   assign genSel = regs_q.genCtrl[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
   assign chkSel = regs_q.chkCtrl[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
   assign genActive = regs_q.genCtrl[`CTRL_EN_BIT] && !regs_q.genCtrl[`CTRL_RST_BIT];
   assign chkActive = regs_q.chkCtrl[`CTRL_EN_BIT] && !regs_q.chkCtrl[`CTRL_RST_BIT];
   assign errClear = regWrEn && regAddr == `REG_CHK_CTRL && regWrData[`CHK_CLR_BIT];
   // a falling bit7 can only follow a written one after a zero: the 0,1,0 sequence
   assign injectReq = regWrEn && regAddr == `REG_GEN_CTRL &&
                      regs_q.genCtrl[`GEN_ERRINJ_BIT] && !regWrData[`GEN_ERRINJ_BIT];

   always_comb begin
      regs_d = regs_q;
      if (regWrEn) begin
         unique case (regAddr)
            `REG_GEN_CTRL: regs_d.genCtrl = regWrData;
            `REG_CHK_CTRL: regs_d.chkCtrl = {1'b0, 1'b0, regWrData[5:0]};
            `REG_USER_W0: regs_d.userPat[7:0] = regWrData;
            `REG_USER_W1: regs_d.userPat[15:8] = regWrData;
            `REG_USER_W2: regs_d.userPat[23:16] = regWrData;
            `REG_CHK_CHSEL: regs_d.chkChSel = {5'h00, regWrData[2:0]};
            `REG_GEN_CHSEL: regs_d.genChSel = {6'h00, regWrData[1:0]};
            default: regs_d = regs_q;
         endcase
      end
      errCnt_d = errCnt_q;
      if (!chkActive) begin
         errCnt_d = '0;
      end else if (chkError) begin
         // a new error in the clearing cycle survives as a count of one
         errCnt_d = errClear ? 8'h01 : (errCnt_q == `ERR_MAX) ? errCnt_q : errCnt_q + 8'h01;
      end else if (errClear) begin
         errCnt_d = '0;
      end
      unique case (regAddr)
         `REG_GEN_CTRL: rdData_d = regs_q.genCtrl;
         `REG_CHK_CTRL: rdData_d = regs_q.chkCtrl;
         `REG_USER_W0: rdData_d = regs_q.userPat[7:0];
         `REG_USER_W1: rdData_d = regs_q.userPat[15:8];
         `REG_USER_W2: rdData_d = regs_q.userPat[23:16];
         `REG_CHK_CHSEL: rdData_d = regs_q.chkChSel;
         `REG_GEN_CHSEL: rdData_d = regs_q.genChSel;
         `REG_CHK_ERRCNT: rdData_d = errCnt_q;
         default: rdData_d = '0;
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         regs_q <= '{genCtrl: `GEN_CTRL_RESET, chkCtrl: `CHK_CTRL_RESET,
                     userPat: '0, chkChSel: `ZERO_RESET, genChSel: `ZERO_RESET};
         errCnt_q <= '0;
         regRdData_q <= '0;
      end else begin
         regs_q <= regs_d;
         errCnt_q <= errCnt_d;
         regRdData_q <= rdData_d;
      end
   end

   // ***************************************************************
   // pattern generator
   // ***************************************************************
   pat_state_t genSt_q, genSt_d;
   logic injPend_q, injPend_d;
   logic tx0_d, tx1_d, refRec_d;
   logic fifoInReady, fifoOutValid, fifoOutReady, fifoOutBit, pushBit, tickRise;

   assign tickRise = sync2_q[NSYNC-1] && !syncPrev_q[NSYNC-1];
   assign fifoOutReady = tickRise && genActive;
   // the source stalls while the fifo is full, so no pattern bit is ever dropped
   assign pushBit = patBit(genSt_q, genSel, regs_q.userPat) ^ injPend_q;

   always_comb begin
      genSt_d = genSt_q;
      injPend_d = injPend_q || injectReq;
      if (!genActive) begin
         genSt_d = PAT_INIT;
         injPend_d = 1'b0;
      end else if (fifoInReady) begin
         genSt_d = patStep(genSt_q, genSel, 1'b0, 1'b0, regs_q.userPat);
         injPend_d = injectReq;
      end
      tx0_d = txData0_q;
      tx1_d = txData1_q;
      if (!genActive) begin
         tx0_d = 1'b0;
         tx1_d = 1'b0;
      end else if (tickRise) begin
         // an underrun sends zero rather than repeating a stale bit
         tx0_d = regs_q.genChSel[0] && fifoOutValid && fifoOutBit;
         tx1_d = regs_q.genChSel[1] && fifoOutValid && fifoOutBit;
      end
      refRec_d = regs_q.genCtrl[`GEN_REFSEL_BIT] && checkChanFullRate;
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         genSt_q <= PAT_INIT;
         injPend_q <= 1'b0;
         txData0_q <= 1'b0;
         txData1_q <= 1'b0;
         pllRefRecovered_q <= 1'b0;
      end else begin
         genSt_q <= genSt_d;
         injPend_q <= injPend_d;
         txData0_q <= tx0_d;
         txData1_q <= tx1_d;
         pllRefRecovered_q <= refRec_d;
      end
   end

   bist_fifo #(
      .WIDTH(1),
      .DEPTH(FIFO_DEPTH)
   ) u_tx_fifo (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .flush(!genActive),
      .inValid(genActive),
      .inReady(fifoInReady),
      .inData(pushBit),
      .outValid(fifoOutValid),
      .outReady(fifoOutReady),
      .outData(fifoOutBit)
   );

   // ***************************************************************
   // pattern checker
   // ***************************************************************
   pat_state_t chkSt_q, chkSt_d;
   chk_state_t chkFsm_q, chkFsm_d;
   logic [6:0] goodRun_q, goodRun_d;
   logic selClk, selClkPrev, rxBit, mismatch;
   logic [2:0] chIdx;

   assign chIdx = regs_q.chkChSel[2:0];
   // a select beyond the last channel sees a still clock and checks nothing
   assign selClk = (chIdx < CHANNELS) ? sync2_q[chIdx] : 1'b0;
   assign selClkPrev = (chIdx < CHANNELS) ? syncPrev_q[chIdx] : 1'b0;
   assign rxBit = (chIdx < CHANNELS) ? sync2_q[CHANNELS + chIdx] : 1'b0;
   assign chkEvent = chkActive && selClk && !selClkPrev;
   assign mismatch = rxBit != patBit(chkSt_q, chkSel, regs_q.userPat);
   assign chkError = chkEvent && mismatch && chkFsm_q == CHK_LOCK;

   always_comb begin
      chkSt_d = chkSt_q;
      chkFsm_d = chkFsm_q;
      goodRun_d = goodRun_q;
      if (!chkActive) begin
         chkSt_d = PAT_INIT;
         chkFsm_d = CHK_HUNT;
         goodRun_d = '0;
      end else if (chkEvent) begin
         unique case (chkFsm_q)
            CHK_HUNT: begin
               // outside prbs, a miss holds the reference one bit back: it slips until in phase
               if (!mismatch || chkSel <= SEL_PRBS31) begin
                  chkSt_d = patStep(chkSt_q, chkSel, 1'b1, rxBit, regs_q.userPat);
               end
               goodRun_d = mismatch ? 7'h00 : goodRun_q + 7'h01;
               if (!mismatch && goodRun_q == `LOCK_RUN - 7'h01) begin
                  chkFsm_d = CHK_LOCK;
               end
            end
            CHK_LOCK: begin
               // once aligned the reference runs free, so one bad bit is counted once
               chkSt_d = patStep(chkSt_q, chkSel, 1'b0, rxBit, regs_q.userPat);
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         chkSt_q <= PAT_INIT;
         chkFsm_q <= CHK_HUNT;
         goodRun_q <= '0;
         chkLocked_q <= 1'b0;
      end else begin
         chkSt_q <= chkSt_d;
         chkFsm_q <= chkFsm_d;
         goodRun_q <= goodRun_d;
         chkLocked_q <= chkFsm_d == CHK_LOCK;
      end
   end
endmodule

// file: bist_pattern_gen_checker_checker.sv
`timescale 1ns/1ps
// *****
// port checks
// *****
module bist_pattern_gen_checker_checker (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic regWrEn,
   input wire logic [2:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic [7:0] regRdData_q,
   input wire logic checkChanFullRate,
   input wire logic txData0_q,
   input wire logic txData1_q,
   input wire logic pllRefRecovered_q,
   input wire logic chkLocked_q
);
   logic refSel_q;
   logic refSel_d;
   logic chkWr;
   logic stop;
   logic clr;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   assign chkWr = regWrEn && regAddr == 3'h1;
   assign stop = chkWr && (regWrData[0] || !regWrData[1]);
   // every write that may zero the count, so count steps are judged only in between
   assign clr = stop || (chkWr && regWrData[6]);
   always_comb begin
      refSel_d = refSel_q;
      if (regWrEn && regAddr == 3'h0) begin
         refSel_d = regWrData[6];
      end
   end
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         refSel_q <= 1'b0;
      end else begin
         refSel_q <= refSel_d;
      end
   end
   a_reset_out_zero: assert property (
      $rose(arst_n) |-> !txData0_q && !txData1_q && !chkLocked_q && !pllRefRecovered_q)
      else $error("outputs not zero after reset");
   a_user_readback: assert property (
      (regWrEn && regAddr inside {[3'h2:3'h4]}) ##1 (!regWrEn && regAddr == $past(regAddr))
      |=> regRdData_q == $past(regWrData, 2)) else $error("user word readback wrong");
   a_chsel_mask: assert property (
      (regWrEn && regAddr == 3'h5) ##1 (!regWrEn && regAddr == 3'h5)
      |=> regRdData_q == {5'h00, $past(regWrData[2:0], 2)}) else $error("channel select wrong");
   a_chk_ctrl_mask: assert property (
      chkWr ##1 (!regWrEn && regAddr == 3'h1)
      |=> regRdData_q == ($past(regWrData, 2) & 8'h3F)) else $error("checker control wrong");
   a_tx_disabled_zero: assert property (
      (regWrEn && regAddr == 3'h0 && !regWrData[1]) |-> ##[1:4] (!txData0_q && !txData1_q))
      else $error("tx output not zero after disable");
   a_lock_drop_reset: assert property (
      stop |-> ##[1:4] !chkLocked_q) else $error("lock kept through checker reset");
   a_lock_sticky: assert property (
      $fell(chkLocked_q) |-> $past(stop) || $past(stop, 2) || $past(stop, 3))
      else $error("lock lost without reset");
   a_ref_on: assert property (
      (refSel_q && checkChanFullRate) [*3] |-> pllRefRecovered_q)
      else $error("recovered reference not selected");
   a_ref_off: assert property (
      (!refSel_q || !checkChanFullRate) [*3] |-> !pllRefRecovered_q)
      else $error("recovered reference selected wrongly");
   a_count_step: assert property (
      (regAddr == 3'h7 && $past(regAddr) == 3'h7 && !$past(clr) && !$past(clr, 2))
      |=> (regRdData_q == $past(regRdData_q) || (regRdData_q == $past(regRdData_q) + 8'h01 &&
      $past(regRdData_q) != 8'hFF))) else $error("error count stepped wrongly");
endmodule
bind bist_pattern_gen_checker bist_pattern_gen_checker_checker u_chk (.sys_clk(sys_clk),
   .arst_n(arst_n), .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData),
   .regRdData_q(regRdData_q), .checkChanFullRate(checkChanFullRate), .txData0_q(txData0_q),
   .txData1_q(txData1_q), .pllRefRecovered_q(pllRefRecovered_q), .chkLocked_q(chkLocked_q));

// file: bist_chan_model.sv
`timescale 1ns/1ps
// *****
// recovery channel 0 sending prbs7
// *****
module bist_chan_model (
   input wire logic run,
   input wire logic flipAll,
   input wire logic [15:0] flipAt,
   output logic [3:0] recClk,
   output logic [3:0] recData,
   output logic [15:0] bitCount
);
   logic [6:0] lfsr;
   logic nb;
   initial begin
      recClk = 4'h0;
      recData = 4'h0;
      lfsr = 7'h7F;
      bitCount = 16'h0000;
      #3;
      forever begin
         #40;
         recClk[0] = run;
         #40;
         recClk[0] = 1'b0;
         if (run) begin
            nb = lfsr[6] ^ lfsr[5];
            lfsr = {lfsr[5:0], nb};
            bitCount = bitCount + 16'h0001;
            recData[0] = nb ^ flipAll ^ (bitCount == flipAt);
         end
         // idle channels toggle so a stale level never passes for data
         recData[3:1] = ~recData[3:1];
      end
   end
endmodule

// file: tb.sv
`timescale 1ns/1ps
`include "bist_consts.svh"
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
   $display("CHECK FAILED t=%0t %s", $time, m); end end
module tb;
   import bist_pkg::*;
   typedef struct {logic wr; logic [2:0] a; logic [7:0] d; logic [7:0] e;} reg_row_t;
   typedef struct {pat_sel_t sel; int l; int t; int p; logic [19:0] pat;} gen_row_t;
   logic sys_clk, arst_n, regWrEn, checkChanFullRate, genBitTick, run, flipAll;
   logic [2:0] regAddr;
   logic [7:0] regWrData, regRdData_q, d;
   logic [3:0] recClk, recData;
   logic txData0_q, txData1_q, pllRefRecovered_q, chkLocked_q;
   logic [15:0] flipAt, bitCount;
   logic [0:71] bits;
   int n_mismatch = 0;
   int n_checks = 0;
   int cycles = 0;
   reg_row_t regRows [16] = '{'{0, 0, 0, 8'h01}, '{0, 1, 0, 8'h01}, '{0, 2, 0, 8'h00},
      '{0, 3, 0, 8'h00}, '{0, 4, 0, 8'h00}, '{0, 5, 0, 8'h00}, '{0, 6, 0, 8'h00},
      '{0, 7, 0, 8'h00}, '{1, 2, 8'hA5, 8'hA5}, '{1, 3, 8'h3C, 8'h3C}, '{1, 4, 8'hF1, 8'hF1},
      '{1, 5, 8'hFF, 8'h07}, '{1, 6, 8'hFF, 8'h03}, '{1, 1, 8'hC2, 8'h02},
      '{1, 7, 8'h55, 8'h00}, '{1, 5, 8'h00, 8'h00}};
   // 8b/10b rows only prove that something is sent; the symbols are not decoded here
   gen_row_t genRows [9] = '{'{SEL_PRBS7, `PRBS7_LEN, `PRBS7_TAP, 0, 20'h0},
      '{SEL_PRBS15, `PRBS15_LEN, `PRBS15_TAP, 0, 20'h0},
      '{SEL_PRBS23, `PRBS23_LEN, `PRBS23_TAP, 0, 20'h0},
      '{SEL_PRBS31, `PRBS31_LEN, `PRBS31_TAP, 0, 20'h0}, '{SEL_JITTER, -1, 0, 0, 20'h0},
      '{SEL_RANDOM, -1, 0, 0, 20'h0}, '{SEL_COUNTDOWN, -1, 0, 0, 20'h0},
      '{SEL_USER20, 0, 0, 20, 20'h13CA5}, '{SEL_USER16, 0, 0, 16, 20'h03CA5}};
   bist_pattern_gen_checker u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .regWrEn(regWrEn),
      .regAddr(regAddr), .regWrData(regWrData), .regRdData_q(regRdData_q), .recClk(recClk),
      .recData(recData), .checkChanFullRate(checkChanFullRate), .genBitTick(genBitTick),
      .txData0_q(txData0_q), .txData1_q(txData1_q), .pllRefRecovered_q(pllRefRecovered_q),
      .chkLocked_q(chkLocked_q));
   bist_chan_model u_chan (.run(run), .flipAll(flipAll), .flipAt(flipAt), .recClk(recClk),
      .recData(recData), .bitCount(bitCount));
   // *****
   // bus and bit tasks
   // *****
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      regWrEn = 1'b1;
      regAddr = a;
      regWrData = v;
      @(negedge sys_clk);
      regWrEn = 1'b0;
      @(negedge sys_clk);
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      regAddr = a;
      repeat (2) @(negedge sys_clk);
      v = regRdData_q;
   endtask
   task automatic grab(input int n);
      for (int i = 0; i < n; i++) begin
         genBitTick = 1'b1;
         repeat (4) @(negedge sys_clk);
         genBitTick = 1'b0;
         repeat (4) @(negedge sys_clk);
         bits[i] = txData0_q;
         `CHK(txData1_q, txData0_q, "tx channels differ")
      end
   endtask
   function automatic int score(input gen_row_t r, input int off);
      int best;
      int m;
      best = 0;
      if (r.l < 0) return 0;
      if (r.p == 0) begin
         for (int n = off + r.l; n < off + 64; n++) begin
            if (bits[n] !== (bits[n - r.l] ^ bits[n - r.t])) best++;
         end
      end else begin
         best = 99;
         for (int s = 0; s < r.p; s++) begin
            m = 0;
            for (int k = 0; k < 64; k++) begin
               if (bits[off + k] !== r.pat[r.p - 1 - (k + s) % r.p]) m++;
            end
            if (m < best) best = m;
         end
      end
      return best;
   endfunction
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // *****
   // clock, timeout and tests
   // *****
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         end_sim();
      end
   end
   initial begin
      {arst_n, regWrEn, checkChanFullRate, genBitTick, run, flipAll} = 6'h00;
      regAddr = 3'h0;
      regWrData = 8'h00;
      flipAt = 16'hFFFF;
      repeat (2) @(negedge sys_clk);
      arst_n = 1'b1;
      foreach (regRows[i]) begin
         if (regRows[i].wr) wr(regRows[i].a, regRows[i].d);
         rd(regRows[i].a, d);
         `CHK(d, regRows[i].e, "register value")
      end
      $display("test registers done");
      wr(3'h6, 8'h03);
      foreach (genRows[i]) begin
         wr(3'h0, 8'h01);
         wr(3'h0, {2'b00, genRows[i].sel, 2'b10});
         grab(72);
         `CHK(score(genRows[i], 8), 0, "generator pattern")
         `CHK(|bits[8:71], 1'b1, "generator idle")
      end
      $display("test generator patterns done");
      wr(3'h0, 8'h9E);
      wr(3'h0, 8'h1E);
      grab(72);
      `CHK(score(genRows[8], 0), 1, "injected error count")
      $display("test error injection done");
      for (int i = 0; i < 4; i++) begin
         checkChanFullRate = i[0];
         wr(3'h0, {1'b0, i[1], 6'h02});
         repeat (4) @(negedge sys_clk);
         `CHK(pllRefRecovered_q, i[0] & i[1], "reference select")
      end
      $display("test reference select done");
      wr(3'h5, 8'h00);
      wr(3'h1, 8'h02);
      run = 1'b1;
      rd(3'h7, d);
      repeat (800) @(negedge sys_clk);
      `CHK(chkLocked_q, 1'b1, "checker not aligned")
      rd(3'h7, d);
      `CHK(d, 8'h00, "errors on clean data")
      flipAt = bitCount + 16'h0004;
      repeat (80) @(negedge sys_clk);
      rd(3'h7, d);
      `CHK(d, 8'h01, "single error count")
      flipAll = 1'b1;
      repeat (2400) @(negedge sys_clk);
      flipAll = 1'b0;
      rd(3'h7, d);
      `CHK(d, 8'hFF, "count not saturated")
      // let the last inverted bit clear the synchronisers before the clear
      repeat (16) @(negedge sys_clk);
      wr(3'h1, 8'h42);
      rd(3'h7, d);
      `CHK(d, 8'h00, "count not cleared")
      wr(3'h1, 8'h03);
      rd(3'h7, d);
      `CHK(d, 8'h00, "count under checker reset")
      `CHK(chkLocked_q, 1'b0, "aligned under checker reset")
      wr(3'h5, 8'h01);
      wr(3'h1, 8'h02);
      repeat (800) @(negedge sys_clk);
      `CHK(chkLocked_q, 1'b0, "aligned on idle channel")
      $display("test checker done");
      end_sim();
   end
endmodule
